// file: rtl/adtc_map.svh
`ifndef ADTC_MAP_SVH
`define ADTC_MAP_SVH
// ==========================================================================
// Timing, widths and reset values of the dead-time sequencer
`define ADTC_CLK_PERIOD_NS 40
`define ADTC_MAX_DEAD_NS 400
`define ADTC_RISE_SETTLE_NS 60
`define ADTC_FALL_SETTLE_NS 60
`define ADTC_SLOPE_MV_PER_US 143
`define ADTC_SLOPE_W 8
`define ADTC_TMR_W 8
`define ADTC_FAIL_W 8
`define ADTC_LEM_STEPS 16
`define ADTC_MIN_CYC 1
`endif

// file: rtl/adtc_pkg.sv
// ==========================================================================
// Types shared by the sequencer modules
package adtc_pkg;
  // Operating mode reported by the mode controller
  typedef enum logic [1:0] {
    ADTC_DCM,
    ADTC_PHASE_IN,
    ADTC_CLAMPED,
    ADTC_PHASE_OUT
  } adtc_mode_t;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_LOW_ON,
    ST_RISE_WAIT,
    ST_RISE_SETTLE,
    ST_LEM_HOLD,
    ST_CLAMP_ON,
    ST_NO_CLAMP,
    ST_FALL_WAIT,
    ST_FALL_SETTLE
  } adtc_state_t;
endpackage

// file: rtl/adtc_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "adtc_map.svh"
// ==========================================================================
// Control and status of one down-counting timer
interface adtc_tmr_if;
  logic start;
  logic abort;
  logic [`ADTC_TMR_W-1:0] load;
  logic done;
  logic busy;
  modport ctrl (output start, output abort, output load, input done, input busy);
  modport tmr (input start, input abort, input load, output done, output busy);
endinterface // adtc_tmr_if
`default_nettype wire

// file: rtl/adtc_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "adtc_map.svh"
// ==========================================================================
// Down counter: done pulses once, load cycles after start is taken
module adtc_timer (
  input wire logic clock_in, // Controller clock
  input wire logic rst_n_in, // Async reset, active low
  adtc_tmr_if.tmr tif        // Timer control
);
  logic [`ADTC_TMR_W-1:0] cnt_r;
  logic [`ADTC_TMR_W-1:0] cnt_nxt;
  logic done_r;
  logic done_nxt;

  // Abort beats start so a stale expiry never leaks into the next gap
  always_comb begin
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    if (tif.abort) begin
      cnt_nxt = '0;
    end else if (tif.start) begin
      cnt_nxt = tif.load;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
      done_nxt = (cnt_r == `ADTC_TMR_W'(`ADTC_MIN_CYC));
    end
  end

  // Registers
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign tif.done = done_r;
  assign tif.busy = (cnt_r != '0);
endmodule // adtc_timer
`default_nettype wire

// file: rtl/adtc_ctrl.sv
// Functional notes
// (RQ1) Low side command falling starts the fail-safe maximum dead timer.
// (RQ2) After low side falls, watch the switch node for rising above 10 V.
// (RQ3) Rising detection starts the rise settle timer, separate from the max timer.
// (RQ4) Rise settle expiry turns the clamp gate command on.
// (RQ5) Max expiry before rising detection counts a failure; clamp stays off.
// (RQ6) Clamp command stays high until cycle end, then drops low.
// (RQ7) Clamp command falling restarts the maximum dead timer.
// (RQ8) Falling threshold detection after clamp off starts the fall settle timer.
// (RQ9) Fall settle or max expiry, whichever first, raises the low side command.
// (RQ10) Max timer counts only in full clamped mode, not in phase transitions.
// (RQ11) Max timer is also ignored during soft start leading-edge phase-in.
// (RQ12) Slope compensation setting is fixed at 143 mV/us.
// (RQ13) Max dead and both settle durations are block parameters.
// (RQ14) Clamp on-time grows on entry to clamped mode, shrinks on exit.
`timescale 1ns/1ps
`default_nettype none
`include "adtc_map.svh"
module adtc_ctrl #(
  parameter int CLK_NS = `ADTC_CLK_PERIOD_NS,
  parameter int MAX_DEAD_NS = `ADTC_MAX_DEAD_NS,
  parameter int RISE_SETTLE_NS = `ADTC_RISE_SETTLE_NS,
  parameter int FALL_SETTLE_NS = `ADTC_FALL_SETTLE_NS,
  parameter int LEM_STEPS = `ADTC_LEM_STEPS
) (
  input wire logic clock_in,                    // 25 MHz controller clock
  input wire logic rst_n_in,                    // Async reset, active low
  input wire logic run_in,                      // Switching enabled
  input wire adtc_pkg::adtc_mode_t mode_in,     // Operating mode
  input wire logic soft_start_lem_in,           // Soft start phase-in active
  input wire logic pwm_off_in,                  // Peak current trip, ends low on
  input wire logic cycle_end_in,                // End of switching cycle pulse
  input wire logic switch_node_rise_in,         // Switch node above 10 V
  input wire logic switch_node_fall_in,         // Switch node at fall threshold
  output logic low_side_gate_cmd_out,           // Low side gate command
  output logic clamp_gate_cmd_out,              // Clamp gate command
  output logic [`ADTC_FAIL_W-1:0] fail_count_out, // Missed rise detections
  output logic [`ADTC_SLOPE_W-1:0] slope_comp_out // Ramp slope in mV/us
);
  // ========================================================================
  // Derived cycle counts
  // Max dead time is a longest time: round down; settle times round up
  localparam int MAX_I = MAX_DEAD_NS / CLK_NS; // RQ13
  localparam int RISE_I = (RISE_SETTLE_NS + CLK_NS - 1) / CLK_NS; // RQ13
  localparam int FALL_I = (FALL_SETTLE_NS + CLK_NS - 1) / CLK_NS; // RQ13
  localparam logic [`ADTC_TMR_W-1:0] MAX_CYC =
    `ADTC_TMR_W'((MAX_I < `ADTC_MIN_CYC) ? `ADTC_MIN_CYC : MAX_I);
  localparam logic [`ADTC_TMR_W-1:0] RISE_CYC =
    `ADTC_TMR_W'((RISE_I < `ADTC_MIN_CYC) ? `ADTC_MIN_CYC : RISE_I);
  localparam logic [`ADTC_TMR_W-1:0] FALL_CYC =
    `ADTC_TMR_W'((FALL_I < `ADTC_MIN_CYC) ? `ADTC_MIN_CYC : FALL_I);
  localparam logic [`ADTC_TMR_W-1:0] LEM_MAX = `ADTC_TMR_W'(LEM_STEPS);
  localparam logic [`ADTC_FAIL_W-1:0] FAIL_MAX = '1;
  localparam logic [`ADTC_SLOPE_W-1:0] SLOPE_SET = `ADTC_SLOPE_W'(`ADTC_SLOPE_MV_PER_US);

  // ========================================================================
  // Helpers
  // The fail-safe only guards full clamped operation
  function automatic logic max_enforced(input adtc_pkg::adtc_mode_t m, input logic ss);
    max_enforced = (m == adtc_pkg::ADTC_CLAMPED) && !ss; // RQ10 RQ11
  endfunction

  // Saturating step of the leading-edge delay
  function automatic logic [`ADTC_TMR_W-1:0] step_lem(input logic [`ADTC_TMR_W-1:0] v,
                                                      input logic up);
    if (up) begin
      step_lem = (v >= LEM_MAX) ? LEM_MAX : v + 1'b1;
    end else begin
      step_lem = (v == '0) ? '0 : v - 1'b1;
    end
  endfunction

  // ========================================================================
  // Timers
  adtc_tmr_if max_if ();
  adtc_tmr_if set_if ();

  adtc_timer u_max_tmr (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .tif(max_if)
  );

  // Shared by rise settle, leading-edge hold and fall settle; never two at once
  adtc_timer u_set_tmr (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .tif(set_if)
  );

  // ========================================================================
  // Sequencer
  adtc_pkg::adtc_state_t state_r;
  adtc_pkg::adtc_state_t state_nxt;
  logic low_r;
  logic low_nxt;
  logic clamp_r;
  logic clamp_nxt;
  logic [`ADTC_FAIL_W-1:0] fail_r;
  logic [`ADTC_FAIL_W-1:0] fail_nxt;
  logic [`ADTC_TMR_W-1:0] lem_r;
  logic [`ADTC_TMR_W-1:0] lem_nxt;
  logic [`ADTC_SLOPE_W-1:0] slope_r;
  logic max_start;
  logic max_abort;
  logic set_start;
  logic set_abort;
  logic [`ADTC_TMR_W-1:0] set_load;
  logic enf;

  // Next state, gate commands, failure count and leading-edge delay
  always_comb begin
    state_nxt = state_r;
    low_nxt = low_r;
    clamp_nxt = clamp_r;
    fail_nxt = fail_r;
    lem_nxt = lem_r;
    max_start = 1'b0;
    max_abort = 1'b0;
    set_start = 1'b0;
    set_abort = 1'b0;
    set_load = RISE_CYC;
    enf = max_enforced(mode_in, soft_start_lem_in);
    // Leading-edge delay steps once per switching cycle in phase-in, phase-out and soft start; DCM and clamped mode set it directly
    if (cycle_end_in) begin
      if (soft_start_lem_in) begin
        lem_nxt = step_lem(lem_r, 1'b0); // RQ14
      end else begin
        unique case (mode_in)
          adtc_pkg::ADTC_DCM: lem_nxt = LEM_MAX;
          adtc_pkg::ADTC_PHASE_IN: lem_nxt = step_lem(lem_r, 1'b0); // RQ14
          adtc_pkg::ADTC_CLAMPED: lem_nxt = '0;
          adtc_pkg::ADTC_PHASE_OUT: lem_nxt = step_lem(lem_r, 1'b1); // RQ14
        endcase
      end
    end
    if (!run_in) begin
      state_nxt = adtc_pkg::ST_IDLE;
      low_nxt = 1'b0;
      clamp_nxt = 1'b0;
      max_abort = 1'b1;
      set_abort = 1'b1;
    end else begin
      unique case (state_r)
        adtc_pkg::ST_IDLE: begin
          state_nxt = adtc_pkg::ST_LOW_ON;
          low_nxt = 1'b1;
        end
        adtc_pkg::ST_LOW_ON: begin
          if (pwm_off_in) begin
            low_nxt = 1'b0;
            max_start = 1'b1; // RQ1
            state_nxt = adtc_pkg::ST_RISE_WAIT; // RQ2
          end
        end
        adtc_pkg::ST_RISE_WAIT: begin
          if (switch_node_rise_in) begin
            set_start = 1'b1; // RQ3
            set_load = RISE_CYC;
            state_nxt = adtc_pkg::ST_RISE_SETTLE;
          end else if (max_if.done && enf) begin
            // Count the miss but leave the clamp off: forcing it risks hard switching
            if (fail_r != FAIL_MAX) begin
              fail_nxt = fail_r + 1'b1; // RQ5
            end
            state_nxt = adtc_pkg::ST_NO_CLAMP; // RQ5
          end else if (cycle_end_in) begin
            state_nxt = adtc_pkg::ST_LOW_ON;
            low_nxt = 1'b1;
            max_abort = 1'b1;
          end
        end
        adtc_pkg::ST_RISE_SETTLE: begin
          if (cycle_end_in) begin
            state_nxt = adtc_pkg::ST_LOW_ON;
            low_nxt = 1'b1;
            max_abort = 1'b1;
            set_abort = 1'b1;
          end else if (set_if.done) begin
            if (mode_in == adtc_pkg::ADTC_DCM) begin
              state_nxt = adtc_pkg::ST_NO_CLAMP;
            end else if (lem_r != '0) begin
              set_start = 1'b1; // RQ14
              set_load = lem_r;
              state_nxt = adtc_pkg::ST_LEM_HOLD;
            end else begin
              clamp_nxt = 1'b1; // RQ4
              state_nxt = adtc_pkg::ST_CLAMP_ON;
            end
          end
        end
        adtc_pkg::ST_LEM_HOLD: begin
          if (cycle_end_in) begin
            state_nxt = adtc_pkg::ST_LOW_ON;
            low_nxt = 1'b1;
            max_abort = 1'b1;
            set_abort = 1'b1;
          end else if (set_if.done) begin
            clamp_nxt = 1'b1; // RQ4 RQ14
            state_nxt = adtc_pkg::ST_CLAMP_ON;
          end
        end
        adtc_pkg::ST_CLAMP_ON: begin
          if (cycle_end_in) begin
            clamp_nxt = 1'b0; // RQ6
            max_abort = 1'b0;
            max_start = 1'b1; // RQ7
            state_nxt = adtc_pkg::ST_FALL_WAIT;
          end
        end
        adtc_pkg::ST_NO_CLAMP: begin
          if (cycle_end_in) begin
            state_nxt = adtc_pkg::ST_LOW_ON;
            low_nxt = 1'b1;
            max_abort = 1'b1;
          end
        end
        adtc_pkg::ST_FALL_WAIT: begin
          if (switch_node_fall_in) begin
            set_start = 1'b1; // RQ8
            set_load = FALL_CYC;
            state_nxt = adtc_pkg::ST_FALL_SETTLE;
          end else if ((max_if.done && enf) || cycle_end_in) begin
            state_nxt = adtc_pkg::ST_LOW_ON; // RQ9
            low_nxt = 1'b1;
            max_abort = 1'b1;
          end
        end
        adtc_pkg::ST_FALL_SETTLE: begin
          // Whichever timer ends first closes the gap
          if (set_if.done || (max_if.done && enf) || cycle_end_in) begin
            state_nxt = adtc_pkg::ST_LOW_ON; // RQ9
            low_nxt = 1'b1;
            max_abort = 1'b1;
            set_abort = 1'b1;
          end
        end
      endcase
    end
  end

  assign max_if.start = max_start;
  assign max_if.abort = max_abort;
  assign max_if.load = MAX_CYC;
  assign set_if.start = set_start;
  assign set_if.abort = set_abort;
  assign set_if.load = set_load;

  // Registers; leading-edge delay starts fully phased out
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= adtc_pkg::ST_IDLE;
      low_r <= 1'b0;
      clamp_r <= 1'b0;
      fail_r <= '0;
      lem_r <= LEM_MAX;
      slope_r <= SLOPE_SET;
    end else begin
      state_r <= state_nxt;
      low_r <= low_nxt;
      clamp_r <= clamp_nxt;
      fail_r <= fail_nxt;
      lem_r <= lem_nxt;
      slope_r <= SLOPE_SET; // RQ12
    end
  end

  assign low_side_gate_cmd_out = low_r;
  assign clamp_gate_cmd_out = clamp_r;
  assign fail_count_out = fail_r;
  assign slope_comp_out = slope_r;

  // ========================================================================
  // Checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_low_falls;
    $fell(low_r) && state_r == adtc_pkg::ST_RISE_WAIT;
  endsequence
  sequence s_missed_rise;
    state_r == adtc_pkg::ST_RISE_WAIT && run_in && !switch_node_rise_in && max_if.done &&
      max_enforced(mode_in, soft_start_lem_in) && fail_r != FAIL_MAX;
  endsequence
  sequence s_clamp_release;
    clamp_r && cycle_end_in && run_in;
  endsequence
  sequence s_rearmed;
    !clamp_r && max_if.busy && state_r == adtc_pkg::ST_FALL_WAIT;
  endsequence

  a_max_arm_low: assert property (s_low_falls |-> max_if.busy) // RQ1
    else $error("max dead timer not started on low side fall");
  a_rise_watch: assert property (state_r == adtc_pkg::ST_RISE_WAIT && run_in && // RQ2 RQ3
    switch_node_rise_in |=> state_r == adtc_pkg::ST_RISE_SETTLE && set_if.busy)
    else $error("rise detection did not start settle timer");
  a_clamp_cause: assert property ($rose(clamp_r) |-> $past(set_if.done) && !low_r) // RQ4
    else $error("clamp rose without settle expiry");
  a_fail_count: assert property (s_missed_rise |=> fail_r == $past(fail_r) + 1'b1 // RQ5
    ##0 (!clamp_r) [*2])
    else $error("missed rise not counted or clamp forced");
  a_clamp_hold: assert property (clamp_r && run_in && !cycle_end_in |=> clamp_r) // RQ6
    else $error("clamp dropped before cycle end");
  a_clamp_rearm: assert property (s_clamp_release |=> s_rearmed) // RQ6 RQ7
    else $error("clamp not released or max timer not restarted");
  a_fall_settle: assert property (state_r == adtc_pkg::ST_FALL_WAIT && run_in && // RQ8
    switch_node_fall_in |=> state_r == adtc_pkg::ST_FALL_SETTLE && set_if.busy)
    else $error("fall detection did not start settle timer");
  a_low_return: assert property (state_r == adtc_pkg::ST_FALL_SETTLE && run_in && // RQ9
    set_if.done |=> low_r && !clamp_r)
    else $error("low side not raised after fall settle");
  a_max_blank: assert property (state_r == adtc_pkg::ST_FALL_WAIT && run_in && // RQ10 RQ11
    max_if.done && !switch_node_fall_in && !cycle_end_in &&
    (mode_in != adtc_pkg::ADTC_CLAMPED || soft_start_lem_in) |=> !low_r)
    else $error("max timer honoured outside full clamped mode");
  a_lem_phase_in: assert property (cycle_end_in && // RQ14
    mode_in == adtc_pkg::ADTC_PHASE_IN && lem_r != '0 |=> lem_r == $past(lem_r) - 1'b1)
    else $error("leading edge delay did not shrink");
  a_slope_fixed: assert property (##1 slope_comp_out == SLOPE_SET) // RQ12
    else $error("slope setting changed");
endmodule // adtc_ctrl
`default_nettype wire

// file: test/adtc_sw_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Switch-node comparators of the power stage, seen from the sequencer
module adtc_sw_model (
  input wire logic clock_in,         // Controller clock
  input wire logic rst_n_in,         // Async reset, active low
  input wire logic low_cmd_in,       // Low side gate command
  input wire logic clamp_cmd_in,     // Clamp gate command
  input wire logic [7:0] rise_dly_in, // Cycles to rise above 10 V, 0 = never
  input wire logic [7:0] fall_dly_in, // Cycles to discharge, 0 = never
  output logic rise_out,             // Node above 10 V
  output logic fall_out              // Node at fall threshold
);
  logic node_high_r;
  logic low_q_r;
  logic clamp_q_r;
  logic [1:0] phase_r;
  logic [7:0] cnt_r;

  // Node swings up after the low side lets go and back after the clamp lets go;
  // a zero delay models a stage that never makes the edge, so the timers must act
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      node_high_r <= 1'b0;
      low_q_r <= 1'b0;
      clamp_q_r <= 1'b0;
      phase_r <= 2'h0;
      cnt_r <= 8'h00;
    end else begin
      low_q_r <= low_cmd_in;
      clamp_q_r <= clamp_cmd_in;
      if (low_cmd_in) begin
        node_high_r <= 1'b0;
        phase_r <= 2'h0;
      end else if (low_q_r) begin
        phase_r <= 2'h1;
        cnt_r <= 8'h01;
      end else if (clamp_q_r && !clamp_cmd_in) begin
        phase_r <= 2'h2;
        cnt_r <= 8'h01;
      end else if (phase_r == 2'h1 && rise_dly_in != 8'h00 && cnt_r >= rise_dly_in) begin
        node_high_r <= 1'b1;
        phase_r <= 2'h0;
      end else if (phase_r == 2'h2 && fall_dly_in != 8'h00 && cnt_r >= fall_dly_in) begin
        node_high_r <= 1'b0;
        phase_r <= 2'h0;
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end

  // Both comparators watch the same node
  assign rise_out = node_high_r;
  assign fall_out = !node_high_r;
endmodule // adtc_sw_model
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "adtc_map.svh"
// ==========================================================================
// Self-checking bench for the dead-time sequencer
module tb_top;
  logic clock_in;
  logic rst_n_in;
  logic run;
  adtc_pkg::adtc_mode_t mode;
  logic lem_ss;
  logic pwm_off;
  logic cycle_end;
  logic rise;
  logic fall;
  logic low_cmd;
  logic clamp_cmd;
  logic [`ADTC_FAIL_W-1:0] fails;
  logic [`ADTC_SLOPE_W-1:0] slope;
  logic [7:0] rise_dly;
  logic [7:0] fall_dly;
  int miscompares;
  int cmp_count;

  adtc_ctrl i_adtc_ctrl (.clock_in(clock_in), .rst_n_in(rst_n_in), .run_in(run),
    .mode_in(mode), .soft_start_lem_in(lem_ss), .pwm_off_in(pwm_off),
    .cycle_end_in(cycle_end), .switch_node_rise_in(rise), .switch_node_fall_in(fall),
    .low_side_gate_cmd_out(low_cmd), .clamp_gate_cmd_out(clamp_cmd),
    .fail_count_out(fails), .slope_comp_out(slope));
  adtc_sw_model i_adtc_sw_model (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .low_cmd_in(low_cmd), .clamp_cmd_in(clamp_cmd), .rise_dly_in(rise_dly),
    .fall_dly_in(fall_dly), .rise_out(rise), .fall_out(fall));

  // ========================================================================
  // Shared helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Pulses end just after the sampling edge so outputs have settled
  task automatic pulse_off;
    @(posedge clock_in) pwm_off <= 1'b1;
    @(posedge clock_in) pwm_off <= 1'b0;
    #1;
  endtask

  task automatic pulse_end;
    @(posedge clock_in) cycle_end <= 1'b1;
    @(posedge clock_in) cycle_end <= 1'b0;
    #1;
  endtask

  // Counts settled edges until the chosen signal shows the value; bounded wait
  task automatic wait_for(input int sel, input logic val, output int n);
    logic [3:0] v;
    n = 0;
    v = {fall, rise, clamp_cmd, low_cmd};
    while (n < 200 && v[sel] !== val) begin
      @(posedge clock_in);
      #1;
      n++;
      v = {fall, rise, clamp_cmd, low_cmd};
    end
  endtask

  // One clamped switching cycle with the edge counts that the timers give
  task automatic run_clamped(input int exp_clamp, input int exp_low);
    int n;
    pulse_off();
    check("low off at pwm off", low_cmd, 1'b0);
    wait_for(2, 1'b1, n);
    wait_for(1, 1'b1, n);
    check("edges rise to clamp", n, exp_clamp);
    repeat (5) @(posedge clock_in);
    #1;
    check("clamp held", {low_cmd, clamp_cmd}, 2'b01);
    pulse_end();
    check("clamp off at cycle end", clamp_cmd, 1'b0);
    // Counted from the clamp drop: a node that never discharges leaves only the max timer
    wait_for(0, 1'b1, n);
    check("edges to low on", n, exp_low);
  endtask

  // ========================================================================
  // Scenarios
  task automatic t_reset;
    check("reset outputs", {low_cmd, clamp_cmd, fails}, 10'h000);
    check("slope setting", slope, 8'h8f);
    $display("t_reset done");
  endtask

  task automatic t_lem_entry;
    rise_dly = 8'h02;
    fall_dly = 8'h02;
    run_clamped(21, 7);
    $display("t_lem_entry done");
  endtask

  task automatic t_clamped;
    run_clamped(4, 7);
    check("slope in run", slope, 8'h8f);
    $display("t_clamped done");
  endtask

  task automatic t_missed;
    logic [7:0] f0;
    f0 = fails;
    rise_dly = 8'h00;
    pulse_off();
    repeat (10) @(posedge clock_in);
    #1;
    check("no fail before max", fails, f0);
    @(posedge clock_in);
    #1;
    check("fail counted", fails, f0 + 8'h01);
    repeat (8) @(posedge clock_in);
    #1;
    check("clamp not forced", clamp_cmd, 1'b0);
    pulse_end();
    check("low back on", low_cmd, 1'b1);
    $display("t_missed done");
  endtask

  task automatic t_max_fall;
    rise_dly = 8'h02;
    fall_dly = 8'h00;
    run_clamped(4, 11);
    $display("t_max_fall done");
  endtask

  // Max timer must not act in phase-in, phase-out or soft start phase-in
  task automatic t_unenforced;
    adtc_pkg::adtc_mode_t modes [3];
    logic [7:0] f0;
    // Phase-out first so phase-in starts from a non-zero leading-edge delay
    modes = '{adtc_pkg::ADTC_PHASE_OUT, adtc_pkg::ADTC_PHASE_IN, adtc_pkg::ADTC_CLAMPED};
    rise_dly = 8'h00;
    for (int i = 0; i < 3; i++) begin
      f0 = fails;
      @(posedge clock_in);
      mode <= modes[i];
      lem_ss <= (i == 2);
      pulse_off();
      repeat (20) @(posedge clock_in);
      #1;
      check("fail ignored", fails, f0);
      check("gates held off", {low_cmd, clamp_cmd}, 2'b00);
      pulse_end();
      check("low after cycle end", low_cmd, 1'b1);
    end
    $display("t_unenforced done");
  endtask

  // Discontinuous mode: the node still swings but the clamp is never turned on
  task automatic t_dcm;
    rise_dly = 8'h02;
    @(posedge clock_in) mode <= adtc_pkg::ADTC_DCM;
    pulse_off();
    repeat (12) @(posedge clock_in);
    #1;
    check("dcm gates off", {low_cmd, clamp_cmd}, 2'b00);
    pulse_end();
    check("dcm low back", low_cmd, 1'b1);
    $display("t_dcm done");
  endtask

  // ========================================================================
  // Clock, stimulus and watchdog
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  initial begin
    rst_n_in = 1'b0;
    run = 1'b1;
    mode = adtc_pkg::ADTC_CLAMPED;
    lem_ss = 1'b0;
    pwm_off = 1'b0;
    cycle_end = 1'b0;
    rise_dly = 8'h02;
    fall_dly = 8'h02;
    miscompares = 0;
    cmp_count = 0;
    repeat (5) @(posedge clock_in);
    #1;
    t_reset();
    @(posedge clock_in) rst_n_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    #1;
    t_lem_entry();
    t_clamped();
    t_missed();
    t_max_fall();
    t_unenforced();
    t_dcm();
    results();
  end

  // Whole run needs a few hundred cycles; 3000 cuts a hang short
  initial begin
    #(40 * 3000);
    miscompares++;
    $display("ERROR watchdog expected finish seen timeout");
    results();
  end
endmodule // tb_top
`default_nettype wire
